// >>> hw/cspr_pulse_request.sv
`timescale 1ns/10ps
module cspr_pulse_request (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic defaults_load,
  cspr_cfg_if.user  cfg,
  input  wire logic pulse_up_write,
  input  wire logic pulse_down_write,
  input  wire logic pulse_sequence_done,
  output logic      pulse_up_request,
  output logic      pulse_down_request
);

  logic set_up;
  logic set_down;

  assign set_up   = pulse_up_write && cfg.pulse_control_enable;
  assign set_down = pulse_down_write && cfg.pulse_control_enable;

  // A new request in the completion cycle survives, so it is not lost.
  always_ff @(posedge ref_clk) begin
    if (!rstn || defaults_load) begin
      pulse_up_request   <= 1'b0;
      pulse_down_request <= 1'b0;
    end else begin
      if (set_up) begin
        pulse_up_request <= 1'b1;
      end else if (pulse_sequence_done) begin
        pulse_up_request <= 1'b0;
      end
      if (set_down) begin
        pulse_down_request <= 1'b1;
      end else if (pulse_sequence_done) begin
        pulse_down_request <= 1'b0;
      end
    end
  end

endmodule

// >>> hw/cspr_setpoint_decode.sv
`timescale 1ns/10ps
module cspr_setpoint_decode (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  cspr_cfg_if.user         cfg,
  output logic             charge_disable,
  output logic [12:0]      charge_current_ma,
  output logic [10:0]      precharge_current_ma,
  output logic [10:0]      termination_current_ma,
  output logic [12:0]      charge_voltage_mv,
  output logic [11:0]      fast_charge_threshold_mv,
  output logic [7:0]       recharge_offset_mv
);

  function automatic logic [10:0] offset_current(input logic [3:0] code);
    offset_current = cspr_pkg::LIM_OFS_MA
                   + 11'(code) * cspr_pkg::LIM_STEP_MA;
  endfunction

  // Registered so the analog side sees one settled code per cycle.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      charge_disable           <= 1'b0;
      charge_current_ma        <= 13'h0000;
      precharge_current_ma     <= 11'h000;
      termination_current_ma   <= 11'h000;
      charge_voltage_mv        <= 13'h0000;
      fast_charge_threshold_mv <= 12'h000;
      recharge_offset_mv       <= 8'h00;
    end else begin
      charge_disable <= (cfg.charge_current_limit == 7'h00);
      charge_current_ma <= 13'(cfg.charge_current_limit)
                         * cspr_pkg::CUR_STEP_MA;
      precharge_current_ma <= offset_current(cfg.precharge_current_limit);
      termination_current_ma <=
        offset_current(cfg.termination_current_limit);
      charge_voltage_mv <= cspr_pkg::VOLT_OFS_MV
                         + 13'(cfg.charge_voltage_limit)
                         * cspr_pkg::VOLT_STEP_MV;
      fast_charge_threshold_mv <= cfg.fast_charge_threshold_select ?
        cspr_pkg::THR_HIGH_MV : cspr_pkg::THR_LOW_MV;
      recharge_offset_mv <= cfg.recharge_offset_select ?
        cspr_pkg::RECHG_HIGH_MV : cspr_pkg::RECHG_LOW_MV;
    end
  end

endmodule

// >>> hw/cspr_top.sv
`timescale 1ns/10ps
module cspr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h5a
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        sw_reset_req,
  input  wire logic        wd_expire,
  input  wire logic        pulse_up_write,
  input  wire logic        pulse_down_write,
  input  wire logic        pulse_sequence_done,
  output logic             pulse_control_enable,
  output logic [6:0]       charge_current_limit,
  output logic [3:0]       precharge_current_limit,
  output logic [3:0]       termination_current_limit,
  output logic [5:0]       charge_voltage_limit,
  output logic             fast_charge_threshold_select,
  output logic             recharge_offset_select,
  output logic [7:0]       termination_timer_control,
  output logic             pulse_up_request,
  output logic             pulse_down_request,
  output logic             charge_disable,
  output logic [12:0]      charge_current_ma,
  output logic [10:0]      precharge_current_ma,
  output logic [10:0]      termination_current_ma,
  output logic [12:0]      charge_voltage_mv,
  output logic [11:0]      fast_charge_threshold_mv,
  output logic [7:0]       recharge_offset_mv
);

  cspr_cfg_if cfg ();

  cspr_pkg::cspr_state_t state;
  logic [7:0]  charge_current_control;
  logic [7:0]  precharge_termination_current;
  logic [7:0]  charge_voltage_control;
  logic [7:0]  termination_timer_reg;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  ptr;
  logic        read_mode;
  logic        wr_en;
  logic [7:0]  rdata;
  logic        defaults_load;

  assign defaults_load = sw_reset_req || wd_expire;

  function automatic logic [7:0] clamp_current(input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (d[6:0] > cspr_pkg::CUR_CODE_MAX) begin
      v[6:0] = cspr_pkg::CUR_CODE_MAX;
    end
    clamp_current = v;
  endfunction

  function automatic logic [7:0] clamp_voltage(input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (d[7:2] > cspr_pkg::VOLT_CODE_MAX) begin
      v[7:2] = cspr_pkg::VOLT_CODE_MAX;
    end
    clamp_voltage = v;
  endfunction

  always_comb begin
    case (ptr)
      cspr_pkg::OFS_CURRENT:  rdata = charge_current_control;
      cspr_pkg::OFS_PRE_TERM: rdata = precharge_termination_current;
      cspr_pkg::OFS_VOLTAGE:  rdata = charge_voltage_control;
      cspr_pkg::OFS_TERM_TMR: rdata = termination_timer_reg;
      default:                rdata = 8'h00;
    endcase
  end

  // Pins are synchronous to ref_clk, so one stage of history suffices.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  assign scl_rise  = scl && !scl_q;
  assign scl_fall  = !scl && scl_q;
  assign bus_start = scl && scl_q && sda_q && !sda_in;
  assign bus_stop  = scl && scl_q && !sda_q && sda_in;
  assign sda_out   = 1'b0;

  // Open-drain: a zero is driven by raising sda_oe, a one by release.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state     <= cspr_pkg::ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      ptr       <= 8'h00;
      read_mode <= 1'b0;
      sda_oe    <= 1'b0;
      wr_en     <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        state   <= cspr_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state   <= cspr_pkg::ST_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          cspr_pkg::ST_ADDR,
          cspr_pkg::ST_PTR,
          cspr_pkg::ST_WDATA: begin
            if (scl_rise && bit_cnt != cspr_pkg::BYTE_BITS) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == cspr_pkg::BYTE_BITS) begin
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b1;
              if (state == cspr_pkg::ST_ADDR) begin
                if (shift[7:1] == DEV_ADDR) begin
                  read_mode <= shift[0];
                  state     <= cspr_pkg::ST_ADDR_ACK;
                end else begin
                  sda_oe <= 1'b0;
                  state  <= cspr_pkg::ST_IDLE;
                end
              end else if (state == cspr_pkg::ST_PTR) begin
                ptr   <= shift;
                state <= cspr_pkg::ST_PTR_ACK;
              end else begin
                wr_en <= 1'b1;
                state <= cspr_pkg::ST_WDATA_ACK;
              end
            end
          end
          cspr_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (read_mode) begin
                shift   <= rdata;
                sda_oe  <= !rdata[7];
                bit_cnt <= 4'h1;
                ptr     <= ptr + 8'h01;
                state   <= cspr_pkg::ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state  <= cspr_pkg::ST_PTR;
              end
            end
          end
          cspr_pkg::ST_PTR_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state  <= cspr_pkg::ST_WDATA;
            end
          end
          cspr_pkg::ST_WDATA_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              ptr    <= ptr + 8'h01;
              state  <= cspr_pkg::ST_WDATA;
            end
          end
          cspr_pkg::ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == cspr_pkg::BYTE_BITS) begin
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
                state   <= cspr_pkg::ST_HOST_ACK;
              end else begin
                sda_oe  <= !shift[6];
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          cspr_pkg::ST_HOST_ACK: begin
            // A not-acknowledge ends the read; the host then sends stop.
            if (scl_rise && sda_in) begin
              state <= cspr_pkg::ST_IDLE;
            end else if (scl_fall) begin
              shift   <= rdata;
              sda_oe  <= !rdata[7];
              bit_cnt <= 4'h1;
              ptr     <= ptr + 8'h01;
              state   <= cspr_pkg::ST_RDATA;
            end
          end
          default: begin
            sda_oe <= 1'b0;
            state  <= cspr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // A default load outranks a write landing in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rstn || defaults_load) begin
      charge_current_control        <= cspr_pkg::RST_CURRENT;
      precharge_termination_current <= cspr_pkg::RST_PRE_TERM;
      charge_voltage_control        <= cspr_pkg::RST_VOLTAGE;
      termination_timer_reg         <= cspr_pkg::RST_TERM_TMR;
    end else if (wr_en) begin
      case (ptr)
        cspr_pkg::OFS_CURRENT:
          charge_current_control <= clamp_current(shift);
        cspr_pkg::OFS_PRE_TERM:
          precharge_termination_current <= shift;
        cspr_pkg::OFS_VOLTAGE:
          charge_voltage_control <= clamp_voltage(shift);
        cspr_pkg::OFS_TERM_TMR:
          termination_timer_reg <= shift;
        default: begin
        end
      endcase
    end
  end

  assign cfg.pulse_control_enable =
    charge_current_control[cspr_pkg::POS_PULSE_EN];
  assign cfg.charge_current_limit = charge_current_control[6:0];
  assign cfg.precharge_current_limit = precharge_termination_current[7:4];
  assign cfg.termination_current_limit =
    precharge_termination_current[3:0];
  assign cfg.charge_voltage_limit = charge_voltage_control[7:2];
  assign cfg.fast_charge_threshold_select =
    charge_voltage_control[cspr_pkg::POS_FAST_THR];
  assign cfg.recharge_offset_select =
    charge_voltage_control[cspr_pkg::POS_RECHG];

  assign pulse_control_enable         = cfg.pulse_control_enable;
  assign charge_current_limit         = cfg.charge_current_limit;
  assign precharge_current_limit      = cfg.precharge_current_limit;
  assign termination_current_limit    = cfg.termination_current_limit;
  assign charge_voltage_limit         = cfg.charge_voltage_limit;
  assign fast_charge_threshold_select = cfg.fast_charge_threshold_select;
  assign recharge_offset_select       = cfg.recharge_offset_select;
  assign termination_timer_control    = termination_timer_reg;

  cspr_setpoint_decode u_decode (
    .ref_clk                  (ref_clk),
    .rstn                     (rstn),
    .cfg                      (cfg),
    .charge_disable           (charge_disable),
    .charge_current_ma        (charge_current_ma),
    .precharge_current_ma     (precharge_current_ma),
    .termination_current_ma   (termination_current_ma),
    .charge_voltage_mv        (charge_voltage_mv),
    .fast_charge_threshold_mv (fast_charge_threshold_mv),
    .recharge_offset_mv       (recharge_offset_mv)
  );

  cspr_pulse_request u_pulse (
    .ref_clk             (ref_clk),
    .rstn                (rstn),
    .defaults_load       (defaults_load),
    .cfg                 (cfg),
    .pulse_up_write      (pulse_up_write),
    .pulse_down_write    (pulse_down_write),
    .pulse_sequence_done (pulse_sequence_done),
    .pulse_up_request    (pulse_up_request),
    .pulse_down_request  (pulse_down_request)
  );

endmodule

// >>> shared/cspr_cfg_if.sv
`timescale 1ns/10ps
interface cspr_cfg_if;
  logic       pulse_control_enable;
  logic [6:0] charge_current_limit;
  logic [3:0] precharge_current_limit;
  logic [3:0] termination_current_limit;
  logic [5:0] charge_voltage_limit;
  logic       fast_charge_threshold_select;
  logic       recharge_offset_select;

  modport regs (
    output pulse_control_enable,
    output charge_current_limit,
    output precharge_current_limit,
    output termination_current_limit,
    output charge_voltage_limit,
    output fast_charge_threshold_select,
    output recharge_offset_select
  );

  modport user (
    input pulse_control_enable,
    input charge_current_limit,
    input precharge_current_limit,
    input termination_current_limit,
    input charge_voltage_limit,
    input fast_charge_threshold_select,
    input recharge_offset_select
  );
endinterface

// >>> shared/cspr_pkg.sv
package cspr_pkg;

  localparam logic [7:0] OFS_CURRENT   = 8'h04;
  localparam logic [7:0] OFS_PRE_TERM  = 8'h05;
  localparam logic [7:0] OFS_VOLTAGE   = 8'h06;
  localparam logic [7:0] OFS_TERM_TMR  = 8'h07;

  localparam logic [7:0] RST_CURRENT   = 8'h20;
  localparam logic [7:0] RST_PRE_TERM  = 8'h13;
  localparam logic [7:0] RST_VOLTAGE   = 8'h5e;
  localparam logic [7:0] RST_TERM_TMR  = 8'h9d;

  localparam int         POS_PULSE_EN  = 7;
  localparam int         POS_FAST_THR  = 1;
  localparam int         POS_RECHG     = 0;
  localparam logic [6:0] CUR_CODE_MAX  = 7'h4f;
  localparam logic [5:0] VOLT_CODE_MAX = 6'h30;

  localparam logic [12:0] CUR_STEP_MA  = 13'h0040;
  localparam logic [10:0] LIM_OFS_MA   = 11'h040;
  localparam logic [10:0] LIM_STEP_MA  = 11'h040;
  localparam logic [12:0] VOLT_OFS_MV  = 13'h0f00;
  localparam logic [12:0] VOLT_STEP_MV = 13'h0010;
  localparam logic [11:0] THR_LOW_MV   = 12'haf0;
  localparam logic [11:0] THR_HIGH_MV  = 12'hbb8;
  localparam logic [7:0]  RECHG_LOW_MV = 8'h64;
  localparam logic [7:0]  RECHG_HIGH_MV = 8'hc8;

  localparam logic [3:0] BYTE_BITS     = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_PTR       = 4'h2,
    ST_PTR_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_HOST_ACK  = 4'hc
  } cspr_state_t;

endpackage

// >>> verif/cspr_chk.sv
`timescale 1ns/10ps
module cspr_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        sw_reset_req,
  input wire logic        wd_expire,
  input wire logic        pulse_up_write,
  input wire logic        pulse_sequence_done,
  input wire logic        pulse_control_enable,
  input wire logic [6:0]  charge_current_limit,
  input wire logic [3:0]  precharge_current_limit,
  input wire logic [3:0]  termination_current_limit,
  input wire logic [5:0]  charge_voltage_limit,
  input wire logic        fast_charge_threshold_select,
  input wire logic        recharge_offset_select,
  input wire logic [7:0]  termination_timer_control,
  input wire logic        pulse_up_request,
  input wire logic        charge_disable,
  input wire logic [12:0] charge_current_ma,
  input wire logic [10:0] precharge_current_ma,
  input wire logic [10:0] termination_current_ma,
  input wire logic [12:0] charge_voltage_mv,
  input wire logic [11:0] fast_charge_threshold_mv,
  input wire logic [7:0]  recharge_offset_mv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence pulse_arm;
    pulse_up_write && pulse_control_enable;
  endsequence
  sequence defaults_load;
    sw_reset_req || wd_expire;
  endsequence
  current_clamp_a: assert property (
    charge_current_limit <= 7'h4f) else $error("current code over clamp");
  voltage_clamp_a: assert property (
    charge_voltage_limit <= 6'h30) else $error("voltage code over clamp");
  current_decode_a: assert property ($past(rstn) |->
    charge_current_ma == {$past(charge_current_limit), 6'h00})
    else $error("charge current decode wrong");
  charge_off_a: assert property ($past(rstn) |->
    charge_disable == ($past(charge_current_limit) == 7'h00))
    else $error("charge disable wrong");
  pre_decode_a: assert property ($past(rstn) |->
    precharge_current_ma ==
    11'h040 + {1'b0, $past(precharge_current_limit), 6'h00})
    else $error("precharge decode wrong");
  term_decode_a: assert property ($past(rstn) |->
    termination_current_ma ==
    11'h040 + {1'b0, $past(termination_current_limit), 6'h00})
    else $error("termination decode wrong");
  voltage_decode_a: assert property ($past(rstn) |->
    charge_voltage_mv == 13'h0f00 + {3'h0, $past(charge_voltage_limit), 4'h0})
    else $error("voltage decode wrong");
  thr_select_a: assert property ($past(rstn) |->
    fast_charge_threshold_mv ==
    ($past(fast_charge_threshold_select) ? 12'hbb8 : 12'haf0) &&
    recharge_offset_mv == ($past(recharge_offset_select) ? 8'hc8 : 8'h64))
    else $error("threshold select wrong");
  default_load_a: assert property (defaults_load |=>
    !pulse_control_enable && charge_current_limit == 7'h20 &&
    precharge_current_limit == 4'h1 && charge_voltage_limit == 6'h17 &&
    termination_current_limit == 4'h3 &&
    termination_timer_control == 8'h9d &&
    fast_charge_threshold_select && !recharge_offset_select &&
    !pulse_up_request) else $error("defaults not restored");
  pulse_set_a: assert property (
    pulse_arm ##0 !(sw_reset_req || wd_expire) |=> pulse_up_request)
    else $error("pulse request not set");
  pulse_gate_a: assert property (!pulse_up_request &&
    !(pulse_up_write && pulse_control_enable) |=> !pulse_up_request)
    else $error("pulse request set without cause");
  pulse_clear_a: assert property (
    pulse_sequence_done && !pulse_up_write |=> !pulse_up_request)
    else $error("pulse request not cleared");
endmodule
bind cspr_top cspr_chk cspr_chk_inst (
  .ref_clk(ref_clk), .rstn(rstn), .sw_reset_req(sw_reset_req),
  .wd_expire(wd_expire), .pulse_up_write(pulse_up_write),
  .pulse_sequence_done(pulse_sequence_done),
  .pulse_control_enable(pulse_control_enable),
  .charge_current_limit(charge_current_limit),
  .precharge_current_limit(precharge_current_limit),
  .termination_current_limit(termination_current_limit),
  .termination_timer_control(termination_timer_control),
  .termination_current_ma(termination_current_ma),
  .charge_voltage_limit(charge_voltage_limit),
  .fast_charge_threshold_select(fast_charge_threshold_select),
  .recharge_offset_select(recharge_offset_select),
  .pulse_up_request(pulse_up_request), .charge_disable(charge_disable),
  .charge_current_ma(charge_current_ma),
  .precharge_current_ma(precharge_current_ma),
  .charge_voltage_mv(charge_voltage_mv),
  .fast_charge_threshold_mv(fast_charge_threshold_mv),
  .recharge_offset_mv(recharge_offset_mv)
);

// >>> verif/cspr_host_model.sv
`timescale 1ns/10ps
module cspr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5a
) (
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Data moves only while the clock is low, so no false start or stop.
  task automatic clk_bit(input logic b, output logic got);
    scl = 1'b0;
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    got = sda_line;
    tick(2);
  endtask
  task automatic start_c;
    scl = 1'b0;
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
  endtask
  task automatic stop_c;
    scl = 1'b0;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic byte_x(input logic [7:0] tx, input logic nine,
                        output logic [7:0] rx, output logic a9);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(nine, a9);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(p, 1'b1, rx, a1);
    byte_x(d, 1'b1, rx, a2);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(p, 1'b1, rx, a1);
    start_c();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_x(8'hff, 1'b1, d, a3);
    stop_c();
    ok = !(a0 | a1 | a2) && a3;
  endtask
  task automatic write_pair(input logic [7:0] p, input logic [15:0] d,
                            output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(p, 1'b1, rx, a1);
    byte_x(d[15:8], 1'b1, rx, a2);
    byte_x(d[7:0], 1'b1, rx, a3);
    stop_c();
    ok = !(a0 | a1 | a2 | a3);
  endtask
  task automatic read_pair(input logic [7:0] p, output logic [15:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    logic       a4;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(p, 1'b1, rx, a1);
    start_c();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_x(8'hff, 1'b0, d[15:8], a3);
    byte_x(8'hff, 1'b1, d[7:0], a4);
    stop_c();
    ok = !(a0 | a1 | a2) && a4;
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        ref_clk;
  logic        rstn;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic        sw_reset_req;
  logic        wd_expire;
  logic        pulse_up_write;
  logic        pulse_down_write;
  logic        pulse_sequence_done;
  logic        pulse_control_enable;
  logic [5:0]  charge_voltage_limit;
  logic        pulse_up_request;
  logic        pulse_down_request;
  logic        charge_disable;
  logic [12:0] charge_current_ma;
  logic [12:0] charge_voltage_mv;
  logic [11:0] fast_charge_threshold_mv;
  logic [7:0]  recharge_offset_mv;
  int          n_fail;
  int          samples_checked;
  logic [7:0]  tp[8] = '{8'h04, 8'h04, 8'h04, 8'h04,
                         8'h05, 8'h06, 8'h06, 8'h07};
  logic [7:0]  tw[8] = '{8'hff, 8'h50, 8'h4f, 8'h00,
                         8'ha5, 8'hff, 8'hc1, 8'h3c};
  logic [7:0]  te[8] = '{8'hcf, 8'h4f, 8'h4f, 8'h00,
                         8'ha5, 8'hc3, 8'hc1, 8'h3c};
  // The wire has a pull-up, so a released line reads high.
  wire         sda_line = !(sda_low || (sda_oe && !sda_out));
  always #5 ref_clk = ~ref_clk;
  cspr_top cspr_top_inst (
    .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .sw_reset_req(sw_reset_req),
    .wd_expire(wd_expire), .pulse_up_write(pulse_up_write),
    .pulse_down_write(pulse_down_write),
    .pulse_sequence_done(pulse_sequence_done),
    .pulse_control_enable(pulse_control_enable),
    .charge_current_limit(), .precharge_current_limit(),
    .termination_current_limit(), .charge_voltage_limit(charge_voltage_limit),
    .fast_charge_threshold_select(), .recharge_offset_select(),
    .termination_timer_control(), .pulse_up_request(pulse_up_request),
    .pulse_down_request(pulse_down_request), .charge_disable(charge_disable),
    .charge_current_ma(charge_current_ma), .precharge_current_ma(),
    .termination_current_ma(), .charge_voltage_mv(charge_voltage_mv),
    .fast_charge_threshold_mv(fast_charge_threshold_mv),
    .recharge_offset_mv(recharge_offset_mv)
  );
  cspr_host_model host_inst (
    .ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line)
  );
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host_inst.write_reg(p, d, ok);
    chk(ok, 13'h1, "write ack");
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_inst.read_reg(p, d, ok);
    chk(ok, 13'h1, "read ack");
    chk(d, e, "readback");
  endtask
  task automatic wr2(input logic [7:0] p, input logic [15:0] d);
    logic ok;
    host_inst.write_pair(p, d, ok);
    chk(ok, 13'h1, "burst write ack");
  endtask
  task automatic rd2(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    host_inst.read_pair(p, d, ok);
    chk(ok, 13'h1, "burst read ack");
    chk(d[15:8], e[15:8], "burst first");
    chk(d[7:0], e[7:0], "burst second");
  endtask
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    {sw_reset_req, wd_expire, pulse_up_write} = 3'h0;
    {pulse_down_write, pulse_sequence_done} = 2'h0;
    cyc(12);
    rstn = 1'b1;
    cyc(1);
    rd(8'h04, 8'h20);
    rd(8'h05, 8'h13);
    rd(8'h06, 8'h5e);
    rd(8'h07, 8'h9d);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      wr(tp[i], tw[i]);
      rd(tp[i], te[i]);
    end
    chk(charge_disable, 13'h1, "charge off");
    chk(charge_voltage_mv, 13'h1200, "voltage mv");
    chk(fast_charge_threshold_mv, 13'haf0, "threshold");
    chk(recharge_offset_mv, 13'hc8, "recharge");
    wr(8'h04, 8'h4f);
    chk(charge_current_ma, 13'h13c0, "current ma");
    chk(charge_disable, 13'h0, "charge on");
    rd(8'h10, 8'h00);
    wr2(8'h05, 16'h3cff);
    rd2(8'h05, 16'h3cc3);
    $display("test write readback done");
    pulse(pulse_up_write);
    chk(pulse_up_request, 13'h0, "pulse gated");
    pulse(pulse_down_write);
    chk(pulse_down_request, 13'h0, "down gated");
    wr(8'h04, 8'hcf);
    pulse(pulse_up_write);
    chk(pulse_up_request, 13'h1, "pulse up");
    pulse(pulse_down_write);
    chk(pulse_down_request, 13'h1, "pulse down");
    pulse(pulse_sequence_done);
    chk(pulse_up_request, 13'h0, "up cleared");
    chk(pulse_down_request, 13'h0, "down cleared");
    $display("test pulse done");
    pulse(sw_reset_req);
    cyc(1);
    chk(pulse_control_enable, 13'h0, "enable default");
    rd(8'h04, 8'h20);
    wr(8'h06, 8'h00);
    chk(charge_voltage_limit, 13'h0, "voltage code");
    pulse(wd_expire);
    cyc(1);
    chk(charge_voltage_limit, 13'h17, "voltage default");
    rd(8'h06, 8'h5e);
    $display("test default load done");
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    $display("BAD t=%0t run did not finish", $time);
    wrap_up();
  end
endmodule
